// file: src/rcr_top.sv
// Function
// - Bits 7-4 at index 0x10 pick one of sixteen low-pass bandwidths.
// - Bits 3-0 at index 0x10 set the receive bandwidth, reset 0011.
// - Bits 7-4 at index 0x11 set the complex filter centre, reset 0011.
// - Bit 7 at index 0x12 turns the complex filter on in OOK receive.
// - Bit 6 at index 0x12 bypasses the bit synchroniser in continuous mode.
// - Bit 5 at index 0x12 enables sync word detection, reset off.
// - Bits 4-3 at index 0x12 give a sync length of 8 to 32 bits, reset 11.
// - Bits 2-1 at index 0x12 give zero to three tolerated sync bit errors.
// - Index 0x13 holds the fixed or minimum OOK threshold, reset 0x04.
// - Index 0x14 reads the measured signal strength in half-dB steps.
// - Bits 7-5 at index 0x15 give the threshold decrement size.
// - Bits 4-2 at index 0x15 give the threshold decrement rate.
// - Bits 1-0 at index 0x15 give the averaging cutoff, 01 and 10 reserved.
// - The sync compare widens byte by byte with the length field.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Receive chain side
  input  wire logic        ook_mode_i,
  input  wire logic        cont_mode_i,
  input  wire logic [7:0]  rssi_i,
  input  wire logic        chip_tick_i,
  input  wire logic        sub_tick_i,
  input  wire logic [31:0] sync_word_i,
  input  wire logic        rx_bit_valid_i,
  input  wire logic        rx_bit_i,
  output rcr_rx_cfg_t      rx_cfg_o,
  output logic [7:0]       ook_peak_thr_o,
  output logic [7:0]       ook_avg_thr_o,
  output logic             sync_found_o
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic rcr_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    return (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction : rcr_hit

  function automatic logic rcr_mapped(input logic [7:0] addr);
    return rcr_hit(addr, RCR_IDX_BANDWIDTH) ||
           rcr_hit(addr, RCR_IDX_CENTRE) ||
           rcr_hit(addr, RCR_IDX_SYNC_CTRL) ||
           rcr_hit(addr, RCR_IDX_OOK_THR) ||
           rcr_hit(addr, RCR_IDX_STRENGTH) ||
           rcr_hit(addr, RCR_IDX_OOK_DYN);
  endfunction : rcr_mapped

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [7:0]  bw_q, bw_d;
  logic [7:0]  centre_q, centre_d;
  logic [7:0]  sync_ctrl_q, sync_ctrl_d;
  logic [7:0]  ook_thr_q, ook_thr_d;
  logic [7:0]  strength_q, strength_d;
  logic [7:0]  ook_dyn_q, ook_dyn_d;

  logic        pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        setup;
  logic        wr_commit;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;

  // Setup cycle loads the answer, so the access phase never waits
  assign setup     = psel_i && !penable_i;
  assign wr_commit = psel_i && penable_i && pready_q && pwrite_i &&
                     !pslverr_q && pstrb_i[0];
  assign wbyte     = pwdata_i[7:0];

  always_comb begin
    rd_byte = 8'h00;
    if (rcr_hit(paddr_i, RCR_IDX_BANDWIDTH)) begin
      rd_byte = bw_q;
    end else if (rcr_hit(paddr_i, RCR_IDX_CENTRE)) begin
      rd_byte = centre_q;
    end else if (rcr_hit(paddr_i, RCR_IDX_SYNC_CTRL)) begin
      rd_byte = sync_ctrl_q;
    end else if (rcr_hit(paddr_i, RCR_IDX_OOK_THR)) begin
      rd_byte = ook_thr_q;
    end else if (rcr_hit(paddr_i, RCR_IDX_STRENGTH)) begin
      rd_byte = strength_q;
    end else if (rcr_hit(paddr_i, RCR_IDX_OOK_DYN)) begin
      rd_byte = ook_dyn_q;
    end
  end

  always_comb begin
    pready_d  = setup;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d  = {24'h00_0000, rd_byte};
      // Unmapped words and writes to the read-only word answer with an error
      pslverr_d = !rcr_mapped(paddr_i) ||
                  (pwrite_i && rcr_hit(paddr_i, RCR_IDX_STRENGTH));
    end
  end

  // Reserved bits are stored as written; software keeps them at reset value
  always_comb begin
    bw_d        = bw_q;
    centre_d    = centre_q;
    sync_ctrl_d = sync_ctrl_q;
    ook_thr_d   = ook_thr_q;
    ook_dyn_d   = ook_dyn_q;
    strength_d  = rssi_i;
    if (wr_commit) begin
      if (rcr_hit(paddr_i, RCR_IDX_BANDWIDTH)) begin
        bw_d = wbyte;
      end
      if (rcr_hit(paddr_i, RCR_IDX_CENTRE)) begin
        centre_d = wbyte;
      end
      if (rcr_hit(paddr_i, RCR_IDX_SYNC_CTRL)) begin
        sync_ctrl_d = wbyte;
      end
      if (rcr_hit(paddr_i, RCR_IDX_OOK_THR)) begin
        ook_thr_d = wbyte;
      end
      if (rcr_hit(paddr_i, RCR_IDX_OOK_DYN)) begin
        ook_dyn_d = wbyte;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bw_q        <= RCR_RST_BANDWIDTH;
      centre_q    <= RCR_RST_CENTRE;
      sync_ctrl_q <= RCR_RST_SYNC_CTRL;
      ook_thr_q   <= RCR_RST_OOK_THR;
      strength_q  <= RCR_RST_STRENGTH;
      ook_dyn_q   <= RCR_RST_OOK_DYN;
      pready_q    <= 1'b0;
      prdata_q    <= 32'h0000_0000;
      pslverr_q   <= 1'b0;
    end else begin
      bw_q        <= bw_d;
      centre_q    <= centre_d;
      sync_ctrl_q <= sync_ctrl_d;
      ook_thr_q   <= ook_thr_d;
      strength_q  <= strength_d;
      ook_dyn_q   <= ook_dyn_d;
      pready_q    <= pready_d;
      prdata_q    <= prdata_d;
      pslverr_q   <= pslverr_d;
    end
  end

  assign pready_o  = pready_q;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  // ==========================================================================
  // Settings towards the receive chain
  // ==========================================================================
  rcr_rx_cfg_t cfg_q, cfg_d;

  always_comb begin
    cfg_d = '0;
    cfg_d.lowpass_bandwidth_select = bw_q[RCR_POS_LOWPASS +: 4];
    cfg_d.rx_bandwidth_select      = bw_q[RCR_POS_RX_BW +: 4];
    cfg_d.complex_filter_centre    = centre_q[RCR_POS_CENTRE +: 4];
    // Complex filter only matters while receiving OOK
    cfg_d.complex_filter_on = sync_ctrl_q[RCR_POS_CPLX_EN] &&
                              ook_mode_i;
    // Bypass applies in continuous receive only
    cfg_d.bitsync_bypass    = sync_ctrl_q[RCR_POS_BSYNC_OFF] &&
                              cont_mode_i;
    cfg_d.sync_on   = sync_ctrl_q[RCR_POS_SYNC_ON];
    cfg_d.sync_size = sync_ctrl_q[RCR_POS_SYNC_SIZE +: 2];
    cfg_d.sync_tol  = sync_ctrl_q[RCR_POS_SYNC_TOL +: 2];
    cfg_d.threshold_decrement_size = ook_dyn_q[RCR_POS_DEC_SIZE +: 3];
    cfg_d.threshold_decrement_rate = ook_dyn_q[RCR_POS_DEC_RATE +: 3];
    cfg_d.threshold_average_cutoff = ook_dyn_q[RCR_POS_AVG_CUT +: 2];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign rx_cfg_o = cfg_q;

  // ==========================================================================
  // Average-mode OOK threshold
  // ==========================================================================
  // Accumulator keeps fraction bits so slow cutoffs do not stall on rounding
  logic [12:0]        avg_q, avg_d;
  logic signed [13:0] avg_err;
  logic signed [13:0] avg_step;

  always_comb begin
    avg_err  = $signed({1'b0, rssi_i, 5'b0_0000}) - $signed({1'b0, avg_q});
    // Reserved cutoff codes fall back to the faster corner
    if (ook_dyn_q[RCR_POS_AVG_CUT +: 2] == RCR_AVG_CUT_SLOW) begin
      avg_step = avg_err >>> RCR_AVG_SHIFT_32;
    end else begin
      avg_step = avg_err >>> RCR_AVG_SHIFT_8;
    end
    avg_d = avg_q;
    if (!ook_mode_i) begin
      avg_d = {ook_thr_q, 5'b0_0000};
    end else if (chip_tick_i) begin
      avg_d = 13'(avg_q + 13'(avg_step));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_q <= {RCR_RST_OOK_THR, 5'b0_0000};
    end else begin
      avg_q <= avg_d;
    end
  end

  assign ook_avg_thr_o = avg_q[RCR_AVG_FRAC +: 8];

  // ==========================================================================
  // Datapath helpers
  // ==========================================================================
  rcr_ook_floor u_ook_floor (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .ook_active_i (ook_mode_i),
    .chip_tick_i  (chip_tick_i),
    .sub_tick_i   (sub_tick_i),
    .rssi_i       (rssi_i),
    .min_thr_i    (ook_thr_q),
    .dec_size_i   (ook_dyn_q[RCR_POS_DEC_SIZE +: 3]),
    .dec_rate_i   (ook_dyn_q[RCR_POS_DEC_RATE +: 3]),
    .peak_thr_o   (ook_peak_thr_o)
  );

  rcr_sync_detect u_sync_detect (
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .sync_on_i      (sync_ctrl_q[RCR_POS_SYNC_ON]),
    .sync_size_i    (sync_ctrl_q[RCR_POS_SYNC_SIZE +: 2]),
    .sync_tol_i     (sync_ctrl_q[RCR_POS_SYNC_TOL +: 2]),
    .sync_word_i    (sync_word_i),
    .rx_bit_valid_i (rx_bit_valid_i),
    .rx_bit_i       (rx_bit_i),
    .sync_found_o   (sync_found_o)
  );

endmodule : rcr_top
`default_nettype wire

// file: src/rcr_pkg.sv
package rcr_pkg;

  // ==========================================================================
  // Register indexes (byte address is four times the index)
  // ==========================================================================
  localparam logic [5:0] RCR_IDX_BANDWIDTH = 6'h10;
  localparam logic [5:0] RCR_IDX_CENTRE    = 6'h11;
  localparam logic [5:0] RCR_IDX_SYNC_CTRL = 6'h12;
  localparam logic [5:0] RCR_IDX_OOK_THR   = 6'h13;
  localparam logic [5:0] RCR_IDX_STRENGTH  = 6'h14;
  localparam logic [5:0] RCR_IDX_OOK_DYN   = 6'h15;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RCR_RST_BANDWIDTH = 8'hA3;
  localparam logic [7:0] RCR_RST_CENTRE    = 8'h38;
  localparam logic [7:0] RCR_RST_SYNC_CTRL = 8'h18;
  localparam logic [7:0] RCR_RST_OOK_THR   = 8'h04;
  localparam logic [7:0] RCR_RST_STRENGTH  = 8'h00;
  localparam logic [7:0] RCR_RST_OOK_DYN   = 8'h00;

  // ==========================================================================
  // Field positions and averaging constants
  // ==========================================================================
  localparam int RCR_POS_LOWPASS   = 4;
  localparam int RCR_POS_RX_BW     = 0;
  localparam int RCR_POS_CENTRE    = 4;
  localparam int RCR_POS_CPLX_EN   = 7;
  localparam int RCR_POS_BSYNC_OFF = 6;
  localparam int RCR_POS_SYNC_ON   = 5;
  localparam int RCR_POS_SYNC_SIZE = 3;
  localparam int RCR_POS_SYNC_TOL  = 1;
  localparam int RCR_POS_DEC_SIZE  = 5;
  localparam int RCR_POS_DEC_RATE  = 2;
  localparam int RCR_POS_AVG_CUT   = 0;
  localparam int RCR_AVG_FRAC      = 5;
  localparam int RCR_AVG_SHIFT_8   = 3;
  localparam int RCR_AVG_SHIFT_32  = 5;
  localparam logic [1:0] RCR_AVG_CUT_SLOW = 2'b11;

  // ==========================================================================
  // Settings driven into the receive chain
  // ==========================================================================
  typedef struct packed {
    logic [3:0] lowpass_bandwidth_select;
    logic [3:0] rx_bandwidth_select;
    logic [3:0] complex_filter_centre;
    logic       complex_filter_on;
    logic       bitsync_bypass;
    logic       sync_on;
    logic [1:0] sync_size;
    logic [1:0] sync_tol;
    logic [2:0] threshold_decrement_size;
    logic [2:0] threshold_decrement_rate;
    logic [1:0] threshold_average_cutoff;
  } rcr_rx_cfg_t;

endpackage : rcr_pkg

// file: src/rcr_sync_detect.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_sync_detect
  import rcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sync_on_i,
  input  wire logic [1:0]  sync_size_i,
  input  wire logic [1:0]  sync_tol_i,
  input  wire logic [31:0] sync_word_i,
  input  wire logic        rx_bit_valid_i,
  input  wire logic        rx_bit_i,
  output logic             sync_found_o
);

  // ==========================================================================
  // Bit error count
  // ==========================================================================
  function automatic logic [5:0] rcr_ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : rcr_ones

  logic [31:0] shift_q, shift_d;
  logic [5:0]  fill_q, fill_d;
  logic        found_q, found_d;
  logic [31:0] target;
  logic [31:0] mask;
  logic [5:0]  len_bits;
  logic [5:0]  errs;

  // First sync byte always, later bytes as the length field widens
  always_comb begin
    target   = sync_word_i >> (6'd8 * (6'd3 - {4'h0, sync_size_i}));
    mask     = 32'hFFFF_FFFF >> (6'd8 * (6'd3 - {4'h0, sync_size_i}));
    len_bits = 6'd8 * ({4'h0, sync_size_i} + 6'd1);
  end

  always_comb begin
    shift_d = shift_q;
    fill_d  = fill_q;
    found_d = 1'b0;
    errs    = 6'h00;
    if (!sync_on_i) begin
      fill_d = 6'h00;
    end else if (rx_bit_valid_i) begin
      shift_d = {shift_q[30:0], rx_bit_i};
      fill_d  = (fill_q == 6'd32) ? fill_q : fill_q + 6'd1;
      errs    = rcr_ones((shift_d ^ target) & mask);
      // Tolerance admits up to sync_tol_i wrong bits (zero to three) in the window
      found_d = (fill_d >= len_bits) &&
                (errs <= {4'h0, sync_tol_i});
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= 32'h0000_0000;
      fill_q  <= 6'h00;
      found_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      fill_q  <= fill_d;
      found_q <= found_d;
    end
  end

  assign sync_found_o = found_q;

endmodule : rcr_sync_detect
`default_nettype wire

// file: src/rcr_ook_floor.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_ook_floor
  import rcr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ook_active_i,
  input  wire logic       chip_tick_i,
  input  wire logic       sub_tick_i,
  input  wire logic [7:0] rssi_i,
  input  wire logic [7:0] min_thr_i,
  input  wire logic [2:0] dec_size_i,
  input  wire logic [2:0] dec_rate_i,
  output logic [7:0]      peak_thr_o
);

  // ==========================================================================
  // Decrement size in half-dB steps
  // ==========================================================================
  function automatic logic [7:0] rcr_step(input logic [2:0] code);
    logic [7:0] s;
    s = code[2] ? 8'd6 + 8'd2 * {6'h00, code[1:0]} : {5'h00, code} + 8'd1;
    return s;
  endfunction : rcr_step

  logic [2:0] chip_cnt_q, chip_cnt_d;
  logic [3:0] sub_cnt_q, sub_cnt_d;
  logic [7:0] thr_q, thr_d;
  logic       fire;
  logic [8:0] lowered;

  // Slow codes count chips, fast codes count sixteenths of a chip
  always_comb begin
    chip_cnt_d = chip_tick_i ? chip_cnt_q + 3'd1 : chip_cnt_q;
    sub_cnt_d  = sub_tick_i ? sub_cnt_q + 4'd1 : sub_cnt_q;
    if (dec_rate_i[2]) begin
      fire = sub_tick_i &&
             ((sub_cnt_q & (4'b0111 >> dec_rate_i[1:0])) == 4'h0);
    end else begin
      fire = chip_tick_i &&
             ((chip_cnt_q & (3'b111 >> (2'd3 - dec_rate_i[1:0]))) == 3'h0);
    end
  end

  always_comb begin
    thr_d   = thr_q;
    lowered = {1'b0, thr_q} - {1'b0, rcr_step(dec_size_i)};
    if (!ook_active_i || thr_q < min_thr_i) begin
      thr_d = min_thr_i;
    end else if (rssi_i > thr_q) begin
      thr_d = rssi_i;
    end else if (fire) begin
      // Never sink below the programmed floor, and never wrap
      if (lowered[8] || lowered[7:0] < min_thr_i) begin
        thr_d = min_thr_i;
      end else begin
        thr_d = lowered[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chip_cnt_q <= 3'h0;
      sub_cnt_q  <= 4'h0;
      thr_q      <= RCR_RST_OOK_THR;
    end else begin
      chip_cnt_q <= chip_cnt_d;
      sub_cnt_q  <= sub_cnt_d;
      thr_q      <= thr_d;
    end
  end

  assign peak_thr_o = thr_q;

endmodule : rcr_ook_floor
`default_nettype wire

// file: test/rcr_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_top_properties
  import rcr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        ook_mode_i,
  input wire logic        cont_mode_i,
  input wire logic [7:0]  rssi_i,
  input wire logic        chip_tick_i,
  input wire logic        sub_tick_i,
  input wire logic [31:0] sync_word_i,
  input wire logic        rx_bit_valid_i,
  input wire logic        rx_bit_i,
  input wire rcr_rx_cfg_t rx_cfg_o,
  input wire logic [7:0]  ook_peak_thr_o,
  input wire logic [7:0]  ook_avg_thr_o,
  input wire logic        sync_found_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic       acc = psel_i && penable_i && pready_o && pwrite_i
                         && pstrb_i[0] && !pslverr_o;
  wire logic [5:0] ix  = paddr_i[7:2];

  // ========
  // Register access, effects on the receive chain and the sync found pulse
  // ========
  strength_wr_err_a: assert property (
    pready_o && pwrite_i && paddr_i == 8'h50 |-> pslverr_o)
    else $error("write to strength register not refused");
  bw_follow_a: assert property (
    acc && ix == RCR_IDX_BANDWIDTH |-> ##2 rx_cfg_o[26:19] == $past(pwdata_i[7:0], 2))
    else $error("bandwidth fields do not follow write");
  centre_follow_a: assert property (
    acc && ix == RCR_IDX_CENTRE |-> ##2 rx_cfg_o[18:15] == $past(pwdata_i[7:4], 2))
    else $error("centre field does not follow write");
  filter_gate_a: assert property (
    acc && ix == RCR_IDX_SYNC_CTRL |-> ##2 rx_cfg_o.complex_filter_on ==
    ($past(pwdata_i[7], 2) && $past(ook_mode_i)))
    else $error("complex filter enable wrong");
  bypass_gate_a: assert property (
    acc && ix == RCR_IDX_SYNC_CTRL |-> ##2 rx_cfg_o.bitsync_bypass ==
    ($past(pwdata_i[6], 2) && $past(cont_mode_i)))
    else $error("bit synchroniser bypass wrong");
  sync_fields_a: assert property (
    acc && ix == RCR_IDX_SYNC_CTRL |-> ##2 rx_cfg_o[12:8] == $past(pwdata_i[5:1], 2))
    else $error("sync fields do not follow write");
  dyn_follow_a: assert property (
    acc && ix == RCR_IDX_OOK_DYN |-> ##2 rx_cfg_o[7:0] == $past(pwdata_i[7:0], 2))
    else $error("threshold dynamics do not follow write");
  thr_idle_a: assert property (
    acc && ix == RCR_IDX_OOK_THR && !ook_mode_i ##1 (!ook_mode_i) [*2] |->
    ook_peak_thr_o == $past(pwdata_i[7:0], 2) && ook_avg_thr_o == ook_peak_thr_o)
    else $error("threshold outside OOK not the written value");
  found_pulse_a: assert property (
    sync_found_o |-> $past(rx_bit_valid_i) ##1 !sync_found_o)
    else $error("sync found pulse without bit or too long");
  cover property (acc && ix == RCR_IDX_SYNC_CTRL);
  cover property (sync_found_o);
  cover property (pready_o && pslverr_o);
endmodule : rcr_top_properties

bind rcr_top rcr_top_properties u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .ook_mode_i(ook_mode_i), .cont_mode_i(cont_mode_i),
  .rssi_i(rssi_i), .chip_tick_i(chip_tick_i), .sub_tick_i(sub_tick_i),
  .sync_word_i(sync_word_i), .rx_bit_valid_i(rx_bit_valid_i),
  .rx_bit_i(rx_bit_i), .rx_cfg_o(rx_cfg_o), .ook_peak_thr_o(ook_peak_thr_o),
  .ook_avg_thr_o(ook_avg_thr_o), .sync_found_o(sync_found_o)
);
`default_nettype wire

// file: test/rcr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_top_tb
  import rcr_pkg::*;
;
  logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        ook_mode_i, cont_mode_i, chip_tick_i, sub_tick_i, re;
  logic        rx_bit_valid_i, rx_bit_i, sync_found_o;
  logic [3:0]  pstrb_i;
  logic [7:0]  paddr_i, rssi_i, ook_peak_thr_o, ook_avg_thr_o;
  logic [31:0] pwdata_i, prdata_o, sync_word_i, rv;
  rcr_rx_cfg_t rx_cfg_o;
  int          fail_count, checks_done;

  rcr_top uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .ook_mode_i(ook_mode_i), .cont_mode_i(cont_mode_i),
    .rssi_i(rssi_i), .chip_tick_i(chip_tick_i), .sub_tick_i(sub_tick_i),
    .sync_word_i(sync_word_i), .rx_bit_valid_i(rx_bit_valid_i),
    .rx_bit_i(rx_bit_i), .rx_cfg_o(rx_cfg_o), .ook_peak_thr_o(ook_peak_thr_o),
    .ook_avg_thr_o(ook_avg_thr_o), .sync_found_o(sync_found_o)
  );

  always #12.5 clk_i = ~clk_i;

  // ========
  // Checking, bus and tick tasks
  // ========
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0000_00, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      fail_count++;
      $display("ERROR pready_o expected 1 seen %b", pready_o);
      results();
    end else begin
      rv = prdata_o;
      re = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr_o", {31'h0, e}, {31'h0, re});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 8'h00);
    chk("pslverr_o", {31'h0, e}, {31'h0, re});
    if (!e) chk("prdata_o", x, rv);
  endtask : rd

  task automatic pulse(input logic chip);
    chip_tick_i <= chip;
    sub_tick_i <= !chip;
    @(posedge clk_i);
    chip_tick_i <= 1'b0;
    sub_tick_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  // ========
  // Scenarios
  // ========
  task automatic t_reset();
    logic [7:0] tab [6];
    tab = '{RCR_RST_BANDWIDTH, RCR_RST_CENTRE, RCR_RST_SYNC_CTRL,
            RCR_RST_OOK_THR, RCR_RST_STRENGTH, RCR_RST_OOK_DYN};
    chk("rx_cfg_o", {5'h00, 4'hA, 4'h3, 4'h3, 5'h03, 10'h000}, {5'h00, rx_cfg_o});
    for (int i = 0; i < 6; i++) rd({RCR_IDX_BANDWIDTH + 6'(i), 2'b00}, {24'h0000_00, tab[i]}, 1'b0);
  endtask : t_reset

  task automatic t_rw();
    logic [7:0] p;
    logic       m;
    logic [5:0] ix [5];
    logic [7:0] w [5];
    ix = '{RCR_IDX_BANDWIDTH, RCR_IDX_CENTRE, RCR_IDX_SYNC_CTRL,
           RCR_IDX_OOK_THR, RCR_IDX_OOK_DYN};
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 8'h5C : (k == 1) ? 8'hA7 : 8'hFF;
      // Reserved bits keep their reset value, cutoff codes stay 00 or 11
      w = '{p, {p[7:4], 4'h8}, {p[7:1], 1'b0}, p, p};
      m = (k != 2);
      ook_mode_i <= m;
      cont_mode_i <= m;
      for (int i = 0; i < 5; i++) wr({ix[i], 2'b00}, w[i], 1'b0);
      for (int i = 0; i < 5; i++) rd({ix[i], 2'b00}, {24'h0000_00, w[i]}, 1'b0);
      chk("rx_cfg_o", {5'h00, p[7:4], p[3:0], p[7:4], p[7] & m, p[6] & m, p[5],
          p[4:1], p[7:5], p[4:2], p[1:0]}, {5'h00, rx_cfg_o});
    end
  endtask : t_rw

  task automatic t_strength();
    rssi_i <= 8'hC3;
    repeat (3) @(posedge clk_i);
    rd(8'h50, 32'h0000_00C3, 1'b0);
    wr(8'h50, 8'h3C, 1'b1);
    rd(8'h50, 32'h0000_00C3, 1'b0);
    rd(8'h58, 32'h0000_0000, 1'b1);
    wr(8'h41, 8'h00, 1'b1);
    rd(8'h40, 32'h0000_00FF, 1'b0);
  endtask : t_strength

  task automatic t_sync();
    // Case byte: enable, found, size code, tolerance code, flipped bits
    logic [7:0] tab [7];
    logic [7:0] t;
    logic       early;
    int         n;
    tab = '{8'hC0, 8'h81, 8'hD5, 8'hEA, 8'hFF, 8'hBB, 8'h00};
    sync_word_i <= 32'hA5C3_0F96;
    for (int c = 0; c < 7; c++) begin
      t = tab[c];
      wr(8'h48, 8'h00, 1'b0);
      wr(8'h48, {2'b00, t[7], t[5:4], t[3:2], 1'b0}, 1'b0);
      repeat (3) @(posedge clk_i);
      n = 8 * (t[5:4] + 1);
      early = 1'b0;
      for (int i = 0; i < n; i++) begin
        rx_bit_valid_i <= 1'b1;
        rx_bit_i <= sync_word_i[31 - i] ^ (i < t[1:0]);
        @(posedge clk_i);
        rx_bit_valid_i <= 1'b0;
        @(posedge clk_i);
        if (i < n - 1) early = early | sync_found_o;
      end
      chk("sync_found_o", {30'h0, 1'b0, t[6]}, {30'h0, early, sync_found_o});
    end
  endtask : t_sync

  task automatic t_ook();
    ook_mode_i <= 1'b0;
    rssi_i <= 8'h30;
    wr(8'h4C, 8'h20, 1'b0);
    wr(8'h54, 8'hE0, 1'b0);
    chk("ook_peak_thr_o", 32'h0000_0020, {24'h0000_00, ook_peak_thr_o});
    chk("ook_avg_thr_o", 32'h0000_0020, {24'h0000_00, ook_avg_thr_o});
    ook_mode_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("ook_peak_thr_o", 32'h0000_0030, {24'h0000_00, ook_peak_thr_o});
    rssi_i <= 8'h00;
    pulse(1'b1);
    chk("ook_peak_thr_o", 32'h0000_0024, {24'h0000_00, ook_peak_thr_o});
    chk("ook_avg_thr_o", 32'h0000_001C, {24'h0000_00, ook_avg_thr_o});
    pulse(1'b1);
    chk("ook_peak_thr_o", 32'h0000_0020, {24'h0000_00, ook_peak_thr_o});
    wr(8'h4C, 8'h00, 1'b0);
    wr(8'h54, 8'h1F, 1'b0);
    pulse(1'b0);
    chk("ook_peak_thr_o", 32'h0000_001F, {24'h0000_00, ook_peak_thr_o});
    // Slow cutoff: one chip tick moves the average by a 32nd of the gap
    pulse(1'b1);
    chk("ook_avg_thr_o", 32'h0000_0017, {24'h0000_00, ook_avg_thr_o});
    chk("ook_peak_thr_o", 32'h0000_001F, {24'h0000_00, ook_peak_thr_o});
  endtask : t_ook

  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    {psel_i, penable_i, pwrite_i, ook_mode_i, cont_mode_i} = '0;
    {chip_tick_i, sub_tick_i, rx_bit_valid_i, rx_bit_i} = '0;
    {paddr_i, pwdata_i, rssi_i, sync_word_i} = '0;
    pstrb_i = 4'hF;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    // Settings show the reset registers only after the first edge out of reset
    repeat (2) @(posedge clk_i);
    t_reset();
    t_rw();
    t_strength();
    t_sync();
    t_ook();
    results();
  end
endmodule : rcr_top_tb
`default_nettype wire
